// [logic/pccm_params.svh]
// Named constants for the press crank contact monitor
`ifndef PCCM_PARAMS_SVH
`define PCCM_PARAMS_SVH

// Clock rate and clear pulse timing
`define PCCM_CLK_KHZ 64'd200000
`define PCCM_CLR_MIN_SHORT_MS 64'd100
`define PCCM_CLR_MIN_LONG_MS 64'd350
`define PCCM_CLR_MAX_MS 64'd30000
`define PCCM_CNT_W 33

// Settling time after reset or run, covers the pin synchronisers
`define PCCM_WARM_MAX 2'h3

// Synchronised pin vector layout
`define PCCM_PIN_W 5
`define PCCM_PIN_TOP 0
`define PCCM_PIN_BOTTOM 1
`define PCCM_PIN_EARLY 2
`define PCCM_PIN_MOTION 3
`define PCCM_PIN_CLEAR 4

// Register map, byte addresses
`define PCCM_ADDR_W 4
`define PCCM_DATA_W 32
`define PCCM_BE_W 4
`define PCCM_BE_LOW 0
`define PCCM_OFS_CTRL 4'h0
`define PCCM_OFS_STATUS 4'h4
`define PCCM_OFS_IRQ_STAT 4'h8
`define PCCM_OFS_IRQ_MASK 4'hc

// Control register fields
`define PCCM_CTRL_W 4
`define PCCM_CTRL_RST 4'h0
`define PCCM_CTRL_EARLY 0
`define PCCM_CTRL_CLEAR 1
`define PCCM_CTRL_LONG 2
`define PCCM_CTRL_SUMMARY 3

// Status register width
`define PCCM_STATUS_W 9

// Interrupt status and mask fields
`define PCCM_IRQ_W 3
`define PCCM_IRQ_RST 3'h0
`define PCCM_IRQ_SEQ 0
`define PCCM_IRQ_STOP 1
`define PCCM_IRQ_CLEAR 2

`endif

// [logic/pccm_pkg.sv]
// Types shared by the press crank contact monitor
`include "pccm_params.svh"
package pccm_pkg;
   typedef enum logic [1:0] {
      ZN_INIT = 2'b00,
      ZN_TOP = 2'b01,
      ZN_STROKE = 2'b10,
      ZN_STARTUP = 2'b11
   } pccm_zone_e;
   typedef logic [`PCCM_CNT_W-1:0] pccm_cnt_t;
   typedef logic [`PCCM_DATA_W-1:0] pccm_word_t;
endpackage : pccm_pkg

// [logic/pccm_sync2.sv]
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`include "pccm_params.svh"
module pccm_sync2
   import pccm_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] q_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule : pccm_sync2

// [logic/pccm_pulse_check.sv]
// Width check of the low-high-low clear pulse
`timescale 1ns/1ps
`include "pccm_params.svh"
module pccm_pulse_check
   import pccm_pkg::*;
#(
   parameter pccm_cnt_t MIN_SHORT = pccm_cnt_t'(1),
   parameter pccm_cnt_t MIN_LONG = pccm_cnt_t'(2),
   parameter pccm_cnt_t MAX_HIGH = pccm_cnt_t'(4)
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic long_i,
   input wire logic pulse_i,
   output logic accept_o
);
   pccm_cnt_t high_cnt_r;
   pccm_cnt_t min_w;
   logic prev_r;
   logic armed_r;
   logic fall_w;

   assign min_w = long_i ? MIN_LONG : MIN_SHORT;
   assign fall_w = prev_r & ~pulse_i;
   // window check on the falling edge
   assign accept_o = enable_i & armed_r & fall_w & (high_cnt_r >= min_w) &
                     (high_cnt_r <= MAX_HIGH);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= pulse_i;
      end
   end

   // a low level must be seen while enabled, so a stuck-high pin never counts
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         armed_r <= 1'b0;
      end else begin
         armed_r <= enable_i & (~pulse_i | armed_r);
      end
   end

   // Saturates one above the limit so an overlong pulse stays rejected
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         high_cnt_r <= '0;
      end else if (!pulse_i) begin
         high_cnt_r <= '0;
      end else if (high_cnt_r <= MAX_HIGH) begin
         high_cnt_r <= high_cnt_r + 1'b1;
      end
   end

   property p_accept_on_fall;
      @(posedge clk_i) disable iff (!rst_n_i)
      accept_o |-> ($past(pulse_i) && !pulse_i && high_cnt_r != '0);
   endproperty
   a_accept_on_fall: assert property (p_accept_on_fall) else $error("clear taken off edge");

   property p_disabled_quiet;
      @(posedge clk_i) disable iff (!rst_n_i)
      !enable_i |=> !accept_o;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("clear taken while off");

   property p_long_min;
      @(posedge clk_i) disable iff (!rst_n_i)
      (accept_o && long_i) |-> (high_cnt_r >= MIN_LONG && $past(pulse_i, 1));
   endproperty
   a_long_min: assert property (p_long_min) else $error("long clear too short");
endmodule : pccm_pulse_check

// [logic/pccm_monitor.sv]
// Crank press contact sequence monitor with Avalon-MM registers
`timescale 1ns/1ps
`include "pccm_params.svh"
module pccm_monitor
   import pccm_pkg::*;
#(
   parameter pccm_cnt_t CLR_MIN_SHORT_CYC = pccm_cnt_t'(`PCCM_CLR_MIN_SHORT_MS * `PCCM_CLK_KHZ),
   parameter pccm_cnt_t CLR_MIN_LONG_CYC = pccm_cnt_t'(`PCCM_CLR_MIN_LONG_MS * `PCCM_CLK_KHZ),
   parameter pccm_cnt_t CLR_MAX_CYC = pccm_cnt_t'(`PCCM_CLR_MAX_MS * `PCCM_CLK_KHZ)
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic drive_cmd_i,
   input wire logic top_center_contact_i,
   input wire logic bottom_center_contact_i,
   input wire logic early_top_contact_i,
   input wire logic motion_enable_i,
   input wire logic clear_request_i,
   input wire logic [`PCCM_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [`PCCM_DATA_W-1:0] avs_writedata_i,
   input wire logic [`PCCM_BE_W-1:0] avs_byteenable_i,
   output logic [`PCCM_DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic press_permit_o,
   output logic top_zone_o,
   output logic startup_zone_o,
   output logic reset_needed_o,
   output logic sequence_fault_o,
   output logic stop_fault_o,
   output logic fault_summary_o,
   output logic irq_o
);
   logic [`PCCM_PIN_W-1:0] pins_raw_w;
   logic [`PCCM_PIN_W-1:0] pins_s;
   logic top_s, bot_s, early_s, motion_s, clear_s;
   logic top_q_r, bot_q_r, early_q_r, run_q_r;
   logic [1:0] warm_r;
   logic warm_done_w, run_rise_w;
   logic top_rise_w, top_fall_w, bot_rise_w, bot_fall_w, early_fall_w;
   logic seq_viol_w, leave_top_w, stop_viol_w, seen_high_r;
   logic clr_accept_w, clr_w;
   pccm_zone_e zone_r, zone_nxt;
   logic seq_fault_r, stop_fault_r, reset_needed_r, permit_r, summary_r;
   logic seq_fault_nxt, stop_fault_nxt, reset_needed_nxt;
   logic top_zone_r, startup_zone_r;
   logic [`PCCM_CTRL_W-1:0] ctrl_r;
   logic [`PCCM_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt_w;
   logic use_early_w, use_clear_w, use_long_w, use_summary_w;
   logic ack_r, req_w, wr_w, lane_w, irq_r;
   pccm_word_t rd_w, readdata_r;
   logic [`PCCM_STATUS_W-1:0] status_w;

   assign pins_raw_w = {clear_request_i, motion_enable_i, early_top_contact_i,
                        bottom_center_contact_i, top_center_contact_i};

   pccm_sync2 #(.WIDTH(`PCCM_PIN_W)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(pins_raw_w),
      .q_o(pins_s)
   );

   assign top_s = pins_s[`PCCM_PIN_TOP];
   assign bot_s = pins_s[`PCCM_PIN_BOTTOM];
   assign early_s = pins_s[`PCCM_PIN_EARLY];
   assign motion_s = pins_s[`PCCM_PIN_MOTION];
   assign clear_s = pins_s[`PCCM_PIN_CLEAR];

   assign use_early_w = ctrl_r[`PCCM_CTRL_EARLY];
   assign use_clear_w = ctrl_r[`PCCM_CTRL_CLEAR];
   assign use_long_w = ctrl_r[`PCCM_CTRL_LONG];
   assign use_summary_w = ctrl_r[`PCCM_CTRL_SUMMARY];

   // Previous levels for edge detection
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         top_q_r <= 1'b0;
         bot_q_r <= 1'b0;
         early_q_r <= 1'b0;
         run_q_r <= 1'b0;
      end else begin
         top_q_r <= top_s;
         bot_q_r <= bot_s;
         early_q_r <= early_s;
         run_q_r <= run_i;
      end
   end

   // Edges are not judged until the synchronisers hold real pin levels
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !run_i) begin
         warm_r <= 2'h0;
      end else if (warm_r != `PCCM_WARM_MAX) begin
         warm_r <= warm_r + 2'h1;
      end
   end

   assign warm_done_w = (warm_r == `PCCM_WARM_MAX);
   assign run_rise_w = run_i & ~run_q_r;
   assign top_rise_w = warm_done_w & top_s & ~top_q_r;
   assign top_fall_w = warm_done_w & ~top_s & top_q_r;
   assign bot_rise_w = warm_done_w & bot_s & ~bot_q_r;
   assign bot_fall_w = warm_done_w & ~bot_s & bot_q_r;
   assign early_fall_w = warm_done_w & use_early_w & early_q_r & ~early_s;

   // edge interleave check, both contacts moving at once is a breach too
   assign seq_viol_w = ((top_rise_w | top_fall_w) & (bot_rise_w | bot_fall_w)) |
                       (top_rise_w & ~bot_s) | (top_fall_w & bot_s) |
                       (bot_rise_w & top_s) | (bot_fall_w & ~top_s);

   // drive command seen high during the top dwell
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         seen_high_r <= 1'b0;
      end else begin
         seen_high_r <= top_s & (seen_high_r | drive_cmd_i);
      end
   end

   // history judged only when leaving top with bottom low
   assign leave_top_w = top_fall_w & ~bot_s;
   assign stop_viol_w = leave_top_w & ~seen_high_r;

   pccm_pulse_check #(
      .MIN_SHORT(CLR_MIN_SHORT_CYC),
      .MIN_LONG(CLR_MIN_LONG_CYC),
      .MAX_HIGH(CLR_MAX_CYC)
   ) u_clear (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(use_clear_w),
      .long_i(use_long_w),
      .pulse_i(clear_s),
      .accept_o(clr_accept_w)
   );

   assign clr_w = clr_accept_w | run_rise_w;

   // Zone tracking
   always_comb begin
      zone_nxt = zone_r;
      if (!warm_done_w) begin
         zone_nxt = ZN_INIT;
      end else begin
         case (zone_r)
            ZN_INIT: begin
               if (top_s) begin
                  zone_nxt = ZN_TOP;
               end else if (bot_s) begin
                  zone_nxt = ZN_STARTUP;
               end else begin
                  zone_nxt = ZN_STROKE;
               end
            end
            ZN_TOP: begin
               if (top_fall_w) begin
                  zone_nxt = ZN_STROKE;
               end
            end
            ZN_STROKE: begin
               if (bot_rise_w) begin
                  zone_nxt = ZN_STARTUP;
               end else if (top_rise_w) begin
                  zone_nxt = ZN_TOP;
               end
            end
            // return to top, early edge may advance it
            ZN_STARTUP: begin
               if (top_rise_w || early_fall_w) begin
                  zone_nxt = ZN_TOP;
               end else if (bot_fall_w) begin
                  zone_nxt = ZN_STROKE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         zone_r <= ZN_INIT;
         top_zone_r <= 1'b0;
         startup_zone_r <= 1'b0;
      end else begin
         zone_r <= zone_nxt;
         top_zone_r <= (zone_nxt == ZN_TOP);
         startup_zone_r <= (zone_nxt == ZN_STARTUP);
      end
   end

   // fault latches, a new fault wins over a clear in the same cycle
   always_comb begin
      seq_fault_nxt = seq_fault_r;
      stop_fault_nxt = stop_fault_r;
      reset_needed_nxt = reset_needed_r;
      if (clr_w) begin
         seq_fault_nxt = 1'b0;
         stop_fault_nxt = 1'b0;
         reset_needed_nxt = 1'b0;
      end
      if (seq_viol_w) begin
         seq_fault_nxt = 1'b1;
         reset_needed_nxt = 1'b1;
      end
      if (stop_viol_w) begin
         stop_fault_nxt = 1'b1;
         reset_needed_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         seq_fault_r <= 1'b0;
         stop_fault_r <= 1'b0;
         reset_needed_r <= 1'b0;
         summary_r <= 1'b0;
      end else begin
         seq_fault_r <= seq_fault_nxt;
         stop_fault_r <= stop_fault_nxt;
         reset_needed_r <= reset_needed_nxt;
         summary_r <= use_summary_w & (seq_fault_nxt | stop_fault_nxt);
      end
   end

   // permit once warm-up ends, motion-enable overrides all
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         permit_r <= 1'b0;
      end else begin
         permit_r <= warm_done_w & run_i & motion_s & ~reset_needed_nxt;
      end
   end

   // Avalon slave, one wait state on every access
   assign req_w = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req_w & ~ack_r;
   assign wr_w = avs_write_i & ack_r;
   assign lane_w = avs_byteenable_i[`PCCM_BE_LOW];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req_w & ~ack_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_r <= `PCCM_CTRL_RST;
         irq_mask_r <= `PCCM_IRQ_RST;
      end else if (wr_w && lane_w) begin
         if (avs_address_i == `PCCM_OFS_CTRL) begin
            ctrl_r <= avs_writedata_i[`PCCM_CTRL_W-1:0];
         end else if (avs_address_i == `PCCM_OFS_IRQ_MASK) begin
            irq_mask_r <= avs_writedata_i[`PCCM_IRQ_W-1:0];
         end
      end
   end

   assign irq_evt_w[`PCCM_IRQ_SEQ] = seq_viol_w;
   assign irq_evt_w[`PCCM_IRQ_STOP] = stop_viol_w;
   assign irq_evt_w[`PCCM_IRQ_CLEAR] = clr_accept_w;

   // Write one to clear, a fresh event wins
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         irq_stat_r <= `PCCM_IRQ_RST;
      end else if (wr_w && lane_w && avs_address_i == `PCCM_OFS_IRQ_STAT) begin
         irq_stat_r <= (irq_stat_r & ~avs_writedata_i[`PCCM_IRQ_W-1:0]) | irq_evt_w;
      end else begin
         irq_stat_r <= irq_stat_r | irq_evt_w;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   assign status_w = {bot_s, top_s, summary_r, stop_fault_r, seq_fault_r,
                      reset_needed_r, startup_zone_r, top_zone_r, permit_r};

   always_comb begin
      rd_w = '0;
      if (avs_address_i == `PCCM_OFS_CTRL) begin
         rd_w[`PCCM_CTRL_W-1:0] = ctrl_r;
      end else if (avs_address_i == `PCCM_OFS_STATUS) begin
         rd_w[`PCCM_STATUS_W-1:0] = status_w;
      end else if (avs_address_i == `PCCM_OFS_IRQ_STAT) begin
         rd_w[`PCCM_IRQ_W-1:0] = irq_stat_r;
      end else if (avs_address_i == `PCCM_OFS_IRQ_MASK) begin
         rd_w[`PCCM_IRQ_W-1:0] = irq_mask_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         readdata_r <= '0;
      end else if (avs_read_i && !ack_r) begin
         readdata_r <= rd_w;
      end
   end

   assign avs_readdata_o = readdata_r;
   assign press_permit_o = permit_r;
   assign top_zone_o = top_zone_r;
   assign startup_zone_o = startup_zone_r;
   assign reset_needed_o = reset_needed_r;
   assign sequence_fault_o = seq_fault_r;
   assign stop_fault_o = stop_fault_r;
   assign fault_summary_o = summary_r;
   assign irq_o = irq_r;

   sequence s_bdc_rise;
      warm_done_w && run_i && zone_r == ZN_STROKE && bot_rise_w && !seq_viol_w;
   endsequence
   sequence s_tdc_return;
      warm_done_w && run_i && zone_r == ZN_STARTUP && top_rise_w && !seq_viol_w;
   endsequence

   property p_motion_off;
      @(posedge clk_i) disable iff (!rst_n_i) !motion_s |=> !press_permit_o;
   endproperty
   a_motion_off: assert property (p_motion_off) else $error("permit with motion off");

   property p_seq_fault;
      @(posedge clk_i) disable iff (!rst_n_i)
      seq_viol_w |=> sequence_fault_o && reset_needed_o && !press_permit_o;
   endproperty
   a_seq_fault: assert property (p_seq_fault) else $error("sequence fault missed");

   property p_stop_fault;
      @(posedge clk_i) disable iff (!rst_n_i)
      stop_viol_w |=> stop_fault_o && reset_needed_o && !press_permit_o;
   endproperty
   a_stop_fault: assert property (p_stop_fault) else $error("stop fault missed");

   property p_stop_on_leave;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(stop_fault_o) |-> $past(leave_top_w) && !$past(top_s) && $past(top_q_r);
   endproperty
   a_stop_on_leave: assert property (p_stop_on_leave) else $error("stop fault off top exit");

   property p_startup_entry;
      @(posedge clk_i) disable iff (!rst_n_i) s_bdc_rise |=> startup_zone_o && !top_zone_o;
   endproperty
   a_startup_entry: assert property (p_startup_entry) else $error("startup zone missed");

   property p_top_return;
      @(posedge clk_i) disable iff (!rst_n_i) s_tdc_return |=> top_zone_o && !startup_zone_o;
   endproperty
   a_top_return: assert property (p_top_return) else $error("top zone missed");

   property p_early_ignored;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!use_early_w && warm_done_w && run_i && zone_r == ZN_STARTUP && !top_rise_w && !bot_fall_w)
      |=> zone_r == ZN_STARTUP;
   endproperty
   a_early_ignored: assert property (p_early_ignored) else $error("early input not ignored");

   property p_early_end;
      @(posedge clk_i) disable iff (!rst_n_i)
      (early_fall_w && warm_done_w && run_i && zone_r == ZN_STARTUP)
      |=> top_zone_o && !startup_zone_o;
   endproperty
   a_early_end: assert property (p_early_end) else $error("early end missed");

   property p_hold_no_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
      (reset_needed_o && !use_clear_w && !run_rise_w) |=> reset_needed_o;
   endproperty
   a_hold_no_clear: assert property (p_hold_no_clear) else $error("reset-needed lost");

   property p_clear_restores;
      @(posedge clk_i) disable iff (!rst_n_i)
      (clr_accept_w && !seq_viol_w && !stop_viol_w)
      |=> !reset_needed_o && !sequence_fault_o && !stop_fault_o && !fault_summary_o;
   endproperty
   a_clear_restores: assert property (p_clear_restores) else $error("clear not applied");

   property p_permit_at_top;
      @(posedge clk_i) disable iff (!rst_n_i)
      (top_zone_o && motion_s && run_i && warm_done_w && !reset_needed_o && !seq_viol_w
       && !stop_viol_w) [*2] |-> press_permit_o;
   endproperty
   a_permit_at_top: assert property (p_permit_at_top) else $error("no permit at top");
endmodule : pccm_monitor

// [bench/pccm_press_model.sv]
// Press contacts and cycle-control stand-in
`timescale 1ns/1ps
module pccm_press_model (
   input wire logic clk_i,
   output logic top_o,
   output logic bottom_o,
   output logic early_o,
   output logic drive_o,
   output logic motion_o,
   output logic clear_o
);
   initial begin
      top_o = 1'b1;
      bottom_o = 1'b0;
      early_o = 1'b1;
      drive_o = 1'b1;
      motion_o = 1'b1;
      clear_o = 1'b0;
   end
   task automatic move(input logic t, input logic b);
      @(posedge clk_i);
      top_o <= t;
      bottom_o <= b;
      repeat (6) @(posedge clk_i);
   endtask : move
   task automatic pin(input int i, input logic v);
      @(posedge clk_i);
      case (i)
         0: early_o <= v;
         1: drive_o <= v;
         default: motion_o <= v;
      endcase
      repeat (6) @(posedge clk_i);
   endtask : pin
   task automatic pulse(input int n);
      @(posedge clk_i);
      clear_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      clear_o <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : pulse
endmodule : pccm_press_model

// [bench/testbench.sv]
// Self-checking bench for the crank contact monitor
`timescale 1ns/1ps
`include "pccm_params.svh"
module testbench import pccm_pkg::*;;
   logic clk_i, rst_n_i, run_i, avs_read_i, avs_write_i;
   logic [3:0] avs_address_i;
   pccm_word_t avs_writedata_i, rd;
   wire logic [31:0] avs_readdata_o;
   wire logic [6:0] outs;
   wire logic avs_waitrequest_o, irq_o, top, bot, early, drv, mot, clr;
   int fails = 0;
   int compares = 0;
   int m_top = 1, m_start = 0, m_seq = 0, m_stop = 0, m_sum = 0, m_mot = 1;
   int wid[7] = '{9, 51, 10, 50, 19, 20, 30};
   int lng[7] = '{0, 0, 0, 0, 1, 1, 0};
   pccm_monitor #(.CLR_MIN_SHORT_CYC(pccm_cnt_t'(10)), .CLR_MIN_LONG_CYC(pccm_cnt_t'(20)),
      .CLR_MAX_CYC(pccm_cnt_t'(50))) DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run_i), .drive_cmd_i(drv),
      .top_center_contact_i(top), .bottom_center_contact_i(bot), .early_top_contact_i(early),
      .motion_enable_i(mot), .clear_request_i(clr), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .press_permit_o(outs[0]), .top_zone_o(outs[1]),
      .startup_zone_o(outs[2]), .reset_needed_o(outs[3]), .sequence_fault_o(outs[4]),
      .stop_fault_o(outs[5]), .fault_summary_o(outs[6]), .irq_o(irq_o));
   pccm_press_model press (.clk_i(clk_i), .top_o(top), .bottom_o(bot), .early_o(early),
      .drive_o(drv), .motion_o(mot), .clear_o(clr));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Masked compare against the reference state
   task automatic chk_out(input logic [6:0] m);
      logic f;
      @(negedge clk_i);
      f = (m_seq != 0) || (m_stop != 0);
      check("outputs", outs & m, {m_sum != 0 && f, m_stop != 0, m_seq != 0, f,
         m_start != 0, m_top != 0, m_mot != 0 && !f} & m);
   endtask : chk_out
   task automatic bus(input logic wr, input logic [3:0] a, input pccm_word_t d);
      logic w;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      // Taken at the completing edge, before that edge updates the slave
      do begin
         @(posedge clk_i);
         w = avs_waitrequest_o;
         rd = avs_readdata_o;
      end while (w !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   task automatic step(input logic t, input logic b, input int mt, input int ms);
      press.move(t, b);
      m_top = mt;
      m_start = ms;
      chk_out(7'h7f);
   endtask : step
   task automatic complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      complete_run();
   end
   initial begin
      rst_n_i = 1'b0;
      run_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 4'h0;
      avs_writedata_i = '0;
      void'($urandom(35226));
      wid[6] = 11 + $urandom % 39;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk_out(7'h7f);
      bus(1'b0, `PCCM_OFS_STATUS, '0);
      check("status", rd, 32'h83);
      bus(1'b0, `PCCM_OFS_CTRL, '0);
      check("ctrl", rd, 32'h0);
      bus(1'b0, 4'h2, '0);
      check("unmapped", rd, 32'h0);
      step(1'b0, 1'b0, 0, 0);
      step(1'b0, 1'b1, 0, 1);
      step(1'b1, 1'b1, 1, 0);
      step(1'b1, 1'b0, 1, 0);
      step(1'b0, 1'b0, 0, 0);
      step(1'b0, 1'b1, 0, 1);
      press.pin(0, 1'b0);
      chk_out(7'h7f);
      press.pin(0, 1'b1);
      bus(1'b1, `PCCM_OFS_CTRL, 32'h1);
      press.pin(0, 1'b0);
      m_top = 1;
      m_start = 0;
      chk_out(7'h7f);
      step(1'b1, 1'b1, 1, 0);
      step(1'b1, 1'b0, 1, 0);
      press.pin(0, 1'b1);
      press.pin(2, 1'b0);
      m_mot = 0;
      chk_out(7'h7f);
      press.pin(2, 1'b1);
      m_mot = 1;
      bus(1'b1, `PCCM_OFS_IRQ_MASK, 32'h7);
      press.move(1'b1, 1'b1);
      m_seq = 1;
      chk_out(7'h79);
      check("irq", irq_o, 1'b1);
      press.move(1'b1, 1'b0);
      bus(1'b1, `PCCM_OFS_CTRL, 32'h8);
      // Summary flop follows the control bit a cycle later
      @(posedge clk_i);
      m_sum = 1;
      chk_out(7'h79);
      press.pulse(20);
      chk_out(7'h79);
      // Boundary widths both sides of each limit
      for (int i = 0; i < 7; i++) begin
         if (m_seq == 0) begin
            press.move(1'b1, 1'b1);
            press.move(1'b1, 1'b0);
            m_seq = 1;
         end
         bus(1'b1, `PCCM_OFS_CTRL, {28'h0, 1'b1, lng[i][0], 2'b10});
         press.pulse(wid[i]);
         if (wid[i] >= (lng[i] != 0 ? 20 : 10) && wid[i] <= 50)
            m_seq = 0;
         chk_out(7'h79);
      end
      bus(1'b0, `PCCM_OFS_IRQ_STAT, '0);
      check("irq_stat", rd, 32'h5);
      bus(1'b1, `PCCM_OFS_IRQ_STAT, 32'h7);
      bus(1'b0, `PCCM_OFS_IRQ_STAT, '0);
      check("irq_stat", rd, 32'h0);
      check("irq", irq_o, 1'b0);
      bus(1'b1, `PCCM_OFS_CTRL, 32'h0);
      m_sum = 0;
      step(1'b0, 1'b0, 0, 0);
      step(1'b0, 1'b1, 0, 1);
      press.pin(1, 1'b0);
      step(1'b1, 1'b1, 1, 0);
      step(1'b1, 1'b0, 1, 0);
      press.move(1'b0, 1'b0);
      m_stop = 1;
      chk_out(7'h79);
      press.pulse(20);
      chk_out(7'h79);
      @(posedge clk_i);
      run_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      run_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      m_stop = 0;
      m_top = 0;
      m_start = 0;
      chk_out(7'h7f);
      complete_run();
   end
endmodule : testbench
